// file: design/mss_pkg.sv
// Constants and types shared by the mode switch supervisor.
// Operation
// - Failed user switch sets error flag and writes three error words.
// - Module check failure still enters virtual but blocks that system.
// - Module check failure raises the axis error signal and stores code.
// - Cam feed within lower limit to stroke; others within stroke limits.
// - Two-way cam: lower limit plus stroke above max signed 32-bit is error.
// - External-input clutch needs on and off devices identical.
// - External-input clutch needs pulse generator input, not serial absolute.
// - Unclutched or clutch-on modules need servo ready set.
// - Unclutched or clutch-on modules must not have stop input asserted.
// - Two-way cam: position within one revolution must be computable.
// - Address-mode clutch setting device must be even-numbered.
// - Missing encoder or cable break raises module error; mode still switches.
// - Real request refused with error while any virtual axis is active.
// - Older firmware also needs real-mode axes stopped before going real.
// - Failed user return to real sets error flag and stores code.
// - Virtual falls back to real on forced stop, host unready, servo error.
// - Automatic fall-back stores code but leaves error flag clear.
// - Servo error policy selects return or continue; defaults to return.
// - Return policy: failing servo off, others rapid stop, re-entry after clear.
// - Continue policy: keep virtual, only failing servo off, clear in virtual.
// - No motion commands during a switch; host gates on request and status.
// - In test mode the request flag is ignored; tool commands are used.
// - Status flag always tracks the mode actually in effect.
package mss_pkg;
  localparam int unsigned MSS_AXES = 8;
  localparam logic [31:0] MSS_INT32_MAX = 32'h7FFFFFFF;
  localparam logic [15:0] MSS_ERR_NONE = 16'h0000;
  localparam logic [15:0] MSS_ERR_NOT_READY = 16'h0001;
  localparam logic [15:0] MSS_ERR_AXIS_BUSY = 16'h0002;
  localparam logic [15:0] MSS_ERR_PREV_FAULT = 16'h0003;
  localparam logic [15:0] MSS_ERR_FORCED_STOP = 16'h0010;
  localparam logic [15:0] MSS_ERR_HOST_UNREADY = 16'h0011;
  localparam logic [15:0] MSS_ERR_SERVO = 16'h0012;
  localparam logic [15:0] MSS_MOD_STROKE = 16'h0100;
  localparam logic [15:0] MSS_MOD_TWO_WAY = 16'h0101;
  localparam logic [15:0] MSS_MOD_CLUTCH_DEV = 16'h0102;
  localparam logic [15:0] MSS_MOD_ENC_IF = 16'h0103;
  localparam logic [15:0] MSS_MOD_SERVO_RDY = 16'h0104;
  localparam logic [15:0] MSS_MOD_STOP_IN = 16'h0105;
  localparam logic [15:0] MSS_MOD_CAM_POS = 16'h0106;
  localparam logic [15:0] MSS_MOD_ADDR_ODD = 16'h0107;
  localparam logic [15:0] MSS_MOD_ENCODER = 16'h0108;
  localparam logic [1:0] MSS_TYPE_CAM = 2'h3;
  localparam logic MSS_POLICY_RETURN = 1'b0;
  typedef enum logic [1:0] {MSS_SRC_USER_V, MSS_SRC_USER_R, MSS_SRC_AUTO} mss_src_e;
  typedef enum {MSS_REAL, MSS_CHECK_V, MSS_VIRTUAL, MSS_CHECK_R} mss_state_e;
endpackage

// file: design/mss_top.sv
// Mode switch supervisor between real and virtual operation.
`timescale 1ns/1ns
`default_nettype none
module mss_top
  import mss_pkg::*;
#(
  parameter int unsigned AXES = MSS_AXES
)(
  // Clock, reset and enable.
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Host flags.
  input wire logic mode_switch_request,
  input wire logic host_ready_flag,
  input wire logic error_clear,
  input wire logic servo_policy_continue,
  input wire logic old_firmware,
  input wire logic forced_stop,
  // Engineering tool test mode.
  input wire logic test_mode,
  input wire logic test_req_virtual,
  input wire logic test_req_real,
  // Per-axis status.
  input wire logic [AXES-1:0] axis_start_accept_flags,
  input wire logic [AXES-1:0] axis_is_virtual,
  input wire logic [AXES-1:0] servo_ready_signal,
  input wire logic [AXES-1:0] servo_error_signal,
  input wire logic [AXES-1:0] stop_input,
  input wire logic [AXES-1:0] clutch_engaged,
  input wire logic [AXES-1:0] clutch_ext_mode,
  input wire logic [AXES-1:0] clutch_same_dev,
  input wire logic [AXES-1:0] enc_serial_abs,
  input wire logic [AXES-1:0] clutch_addr_mode,
  input wire logic [AXES-1:0] addr_dev_lsb,
  input wire logic [AXES-1:0] two_way_cam,
  input wire logic [AXES-1:0] cam_pos_valid,
  input wire logic [AXES-1:0] encoder_present,
  input wire logic [AXES-1:0] encoder_cable_ok,
  input wire logic [AXES*2-1:0] module_type,
  input wire logic [AXES*32-1:0] feed_value,
  input wire logic [AXES*32-1:0] lower_limit,
  input wire logic [AXES*32-1:0] upper_limit,
  input wire logic [AXES*32-1:0] stroke_amount,
  // Mode and error outputs.
  output logic mode_state_flag,
  output logic switch_error_flag,
  output logic [47:0] switch_error_info_words,
  output logic switch_busy,
  output logic motion_cmd_allow,
  output logic [AXES-1:0] module_error_signal,
  output logic [AXES*16-1:0] module_error_code,
  output logic [AXES-1:0] system_start_block,
  output logic [AXES-1:0] servo_off,
  output logic rapid_stop_all
);

  // ---------------------------------------------------------------
  // Request sources and per-axis checks
  // ---------------------------------------------------------------

  mss_state_e state;
  logic req_q;
  logic real_relock;
  logic [AXES-1:0] mod_fail;
  logic [AXES*16-1:0] mod_code;

  // Request edges come from the host flag or, in test mode, the tool.
  logic req_rise;
  logic req_fall;
  assign req_rise = test_mode ? test_req_virtual : (mode_switch_request & ~req_q);
  assign req_fall = test_mode ? test_req_real : (~mode_switch_request & req_q);

  // Each output module's checks evaluate in parallel.
  genvar g;
  generate
    for (g = 0; g < AXES; g++)
    begin : g_chk
      logic signed [31:0] fv;
      logic signed [31:0] lo;
      logic signed [31:0] hi;
      logic signed [31:0] st;
      logic [32:0] sum;
      logic cam;
      logic active;
      logic [15:0] code;
      assign fv = feed_value[g*32 +: 32];
      assign lo = lower_limit[g*32 +: 32];
      assign hi = upper_limit[g*32 +: 32];
      assign st = stroke_amount[g*32 +: 32];
      assign cam = module_type[g*2 +: 2] == MSS_TYPE_CAM;
      assign sum = 33'({lo[31], lo}) + 33'({st[31], st});
      assign active = ~clutch_ext_mode[g] | clutch_engaged[g];
      // First failing check sets the stored code for this module.
      always_comb
      begin
        code = MSS_ERR_NONE;
        if (cam ? (fv < lo || fv > st) : (fv < lo || fv > hi))
          code = MSS_MOD_STROKE;
        else if (cam && two_way_cam[g] && $signed(sum) > $signed({1'b0, MSS_INT32_MAX}))
          code = MSS_MOD_TWO_WAY;
        else if (clutch_ext_mode[g] && !clutch_same_dev[g])
          code = MSS_MOD_CLUTCH_DEV;
        else if (clutch_ext_mode[g] && enc_serial_abs[g])
          code = MSS_MOD_ENC_IF;
        else if (active && !servo_ready_signal[g])
          code = MSS_MOD_SERVO_RDY;
        else if (active && stop_input[g])
          code = MSS_MOD_STOP_IN;
        else if (cam && two_way_cam[g] && !cam_pos_valid[g])
          code = MSS_MOD_CAM_POS;
        else if (clutch_addr_mode[g] && addr_dev_lsb[g])
          code = MSS_MOD_ADDR_ODD;
        else if (!encoder_present[g] || !encoder_cable_ok[g])
          code = MSS_MOD_ENCODER;
      end
      assign mod_fail[g] = code != MSS_ERR_NONE;
      assign mod_code[g*16 +: 16] = code;
    end
  endgenerate

  // Blocking conditions for each direction.
  logic v_block;
  logic [15:0] v_code;
  logic r_block;
  logic any_servo_err;
  assign any_servo_err = |servo_error_signal;
  assign v_block = ~host_ready_flag | (|axis_start_accept_flags) | real_relock | forced_stop;
  assign v_code = ~host_ready_flag ? MSS_ERR_NOT_READY :
                  (|axis_start_accept_flags) ? MSS_ERR_AXIS_BUSY : MSS_ERR_PREV_FAULT;
  assign r_block = old_firmware ? (|axis_start_accept_flags)
                                : (|(axis_start_accept_flags & axis_is_virtual));

  // Automatic fall-back causes while virtual.
  logic auto_fall;
  logic [15:0] auto_code;
  assign auto_fall = forced_stop | ~host_ready_flag |
                     (any_servo_err & (servo_policy_continue == MSS_POLICY_RETURN));
  assign auto_code = forced_stop ? MSS_ERR_FORCED_STOP :
                     ~host_ready_flag ? MSS_ERR_HOST_UNREADY : MSS_ERR_SERVO;

  // ---------------------------------------------------------------
  // Mode state machine
  // ---------------------------------------------------------------

  // Request edge tracker.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      req_q <= 1'b0;
    else if (clk_en)
      req_q <= mode_switch_request;
  end

  // Checks are sampled once, in the cycle after the request edge.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      state <= MSS_REAL;
    else if (clk_en)
    begin
      case (state)
        MSS_REAL:
          if (req_rise)
            state <= MSS_CHECK_V;
        MSS_CHECK_V:
          state <= v_block ? MSS_REAL : MSS_VIRTUAL;
        MSS_VIRTUAL:
          if (auto_fall)
            state <= MSS_REAL;
          else if (req_fall)
            state <= MSS_CHECK_R;
        MSS_CHECK_R:
          if (auto_fall)
            state <= MSS_REAL;
          else
            state <= r_block ? MSS_VIRTUAL : MSS_REAL;
        default:
          state <= MSS_REAL;
      endcase
    end
  end

  // Status follows the mode in force, whatever the source.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      mode_state_flag <= 1'b0;
    else if (clk_en)
      mode_state_flag <= (state == MSS_VIRTUAL) | (state == MSS_CHECK_R);
  end

  // Return-policy servo errors hold off re-entry until cleared in real mode.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      real_relock <= 1'b0;
    else if (clk_en)
    begin
      if (state == MSS_VIRTUAL && any_servo_err && !servo_policy_continue)
        real_relock <= 1'b1;
      else if (state == MSS_REAL && error_clear && !any_servo_err)
        real_relock <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Error reporting
  // ---------------------------------------------------------------

  // Switch error flag and the three information words.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      switch_error_flag <= 1'b0;
      switch_error_info_words <= 48'h000000000000;
    end
    else if (clk_en)
    begin
      if ((state == MSS_VIRTUAL || state == MSS_CHECK_R) && auto_fall)
        switch_error_info_words <= {MSS_ERR_NONE, MSS_ERR_NONE, auto_code};
      else if (state == MSS_CHECK_V && v_block)
      begin
        switch_error_flag <= 1'b1;
        switch_error_info_words <= {MSS_ERR_NONE, MSS_ERR_NONE, v_code};
      end
      else if (state == MSS_CHECK_R && r_block)
      begin
        switch_error_flag <= 1'b1;
        switch_error_info_words <= {MSS_ERR_NONE, MSS_ERR_NONE, MSS_ERR_AXIS_BUSY};
      end
      else if (state == MSS_CHECK_V || state == MSS_CHECK_R || error_clear)
      begin
        switch_error_flag <= 1'b0;
        switch_error_info_words <= 48'h000000000000;
      end
    end
  end

  // Module errors latch on entry to virtual and block that system.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      module_error_signal <= '0;
      module_error_code <= '0;
      system_start_block <= '0;
    end
    else if (clk_en)
    begin
      if (state == MSS_CHECK_V && !v_block)
      begin
        module_error_signal <= mod_fail;
        module_error_code <= mod_code;
        system_start_block <= mod_fail;
      end
      else if (state == MSS_REAL && error_clear)
      begin
        module_error_signal <= '0;
        module_error_code <= '0;
        system_start_block <= '0;
      end
    end
  end

  // Servo of a failing axis off; others rapid stop under return policy.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      servo_off <= '0;
      rapid_stop_all <= 1'b0;
    end
    else if (clk_en)
    begin
      if (error_clear && !(servo_policy_continue ? 1'b0 : mode_state_flag))
        servo_off <= servo_error_signal;
      else
        servo_off <= servo_off | servo_error_signal;
      rapid_stop_all <= (state == MSS_VIRTUAL || state == MSS_CHECK_R) && auto_fall;
    end
  end

  // Motion commands are locked out while a switch is pending.
  assign switch_busy = (state == MSS_CHECK_V) | (state == MSS_CHECK_R) |
                       (mode_switch_request != mode_state_flag);
  assign motion_cmd_allow = ~switch_busy;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------

  chk_auto_no_flag: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clk_en && state == MSS_VIRTUAL && auto_fall && !switch_error_flag)
    |=> !switch_error_flag && switch_error_info_words[15:0] == $past(auto_code))
    else $error("Fall-back must store code without error flag.");
  chk_real_refused: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clk_en && state == MSS_CHECK_R && !auto_fall && r_block) |=> state == MSS_VIRTUAL && switch_error_flag)
    else $error("Busy virtual axis must refuse real switch.");
  chk_virtual_block: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clk_en && state == MSS_CHECK_V && v_block) |=> state == MSS_REAL && switch_error_flag)
    else $error("Blocked virtual switch must flag error.");
  chk_module_enter: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clk_en && state == MSS_CHECK_V && !v_block) |=> state == MSS_VIRTUAL && system_start_block == $past(mod_fail))
    else $error("Module fault must still enter virtual mode.");
  chk_status_track: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $past(clk_en) && $past(rst_n)
    |-> mode_state_flag == ($past(state) == MSS_VIRTUAL || $past(state) == MSS_CHECK_R))
    else $error("Status flag must follow mode.");
  chk_auto_fall: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clk_en && state == MSS_VIRTUAL && forced_stop) |=> state == MSS_REAL ##1 !mode_state_flag)
    else $error("Forced stop must return to real mode.");
  chk_test_ignore: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clk_en && test_mode && !test_req_virtual && state == MSS_REAL) |=> state == MSS_REAL)
    else $error("Request flag must be ignored in test mode.");
  chk_busy_gate: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (state == MSS_CHECK_V || state == MSS_CHECK_R) |-> !motion_cmd_allow)
    else $error("Motion commands must be locked during switch.");
  chk_continue_keep: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clk_en && state == MSS_VIRTUAL && servo_policy_continue && any_servo_err && !forced_stop
     && host_ready_flag && !req_fall) |=> state == MSS_VIRTUAL)
    else $error("Continue policy must keep virtual mode.");

  // Relock, error clearing, module latching, servo off and rapid stop checks.
  chk_relock_entry: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clk_en && state == MSS_CHECK_V && real_relock) |=> state == MSS_REAL && switch_error_flag)
    else $error("Relocked virtual entry must be refused.");
  chk_clear_words: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clk_en && state == MSS_REAL && error_clear)
    |=> !switch_error_flag && switch_error_info_words == 48'h000000000000)
    else $error("Host clear must empty the error flag and words.");
  chk_module_latch: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clk_en && state == MSS_CHECK_V && !v_block)
    |=> module_error_signal == $past(mod_fail) && module_error_code == $past(mod_code))
    else $error("Module errors must latch on virtual entry.");
  chk_servo_set: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clk_en && |servo_error_signal)
    |=> (servo_off & $past(servo_error_signal)) == $past(servo_error_signal))
    else $error("Failing servo must be turned off.");
  chk_rapid_pulse: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clk_en && (state == MSS_VIRTUAL || state == MSS_CHECK_R) && auto_fall) |=> rapid_stop_all)
    else $error("Fall-back must rapid-stop the other axes.");

endmodule // mss_top
`default_nettype wire

// file: sim/mode_switch_supervisor_tb_top.sv
// Self-checking testbench of the mode switch supervisor.
`timescale 1ns/1ns
`default_nettype none
module mode_switch_supervisor_tb_top;
  import mss_pkg::*;
  logic sys_clk, rst_n, clk_en, mode_switch_request, host_ready_flag, error_clear;
  logic servo_policy_continue, old_firmware, forced_stop, test_mode, test_req_virtual;
  logic test_req_real, mode_state_flag, switch_error_flag, switch_busy, motion_cmd_allow;
  logic rapid_stop_all;
  logic [MSS_AXES-1:0] axis_start_accept_flags, axis_is_virtual, servo_ready_signal;
  logic [MSS_AXES-1:0] servo_error_signal, stop_input, clutch_engaged, clutch_ext_mode;
  logic [MSS_AXES-1:0] clutch_same_dev, enc_serial_abs, clutch_addr_mode, addr_dev_lsb;
  logic [MSS_AXES-1:0] two_way_cam, cam_pos_valid, encoder_present, encoder_cable_ok;
  logic [MSS_AXES-1:0] module_error_signal, system_start_block, servo_off;
  logic [MSS_AXES*2-1:0] module_type;
  logic [MSS_AXES*16-1:0] module_error_code;
  logic [MSS_AXES*32-1:0] feed_value, lower_limit, upper_limit, stroke_amount;
  logic [47:0] switch_error_info_words;
  logic [15:0] seed;
  logic [15:0] mod_code [8];
  logic [2:0] seen;
  int errors, n_checks, cyc, a, j, k, r, c;
  mss_top u_dut (.sys_clk, .rst_n, .clk_en, .mode_switch_request, .host_ready_flag,
    .error_clear, .servo_policy_continue, .old_firmware, .forced_stop, .test_mode,
    .test_req_virtual, .test_req_real, .axis_start_accept_flags, .axis_is_virtual,
    .servo_ready_signal, .servo_error_signal, .stop_input, .clutch_engaged, .clutch_ext_mode,
    .clutch_same_dev, .enc_serial_abs, .clutch_addr_mode, .addr_dev_lsb, .two_way_cam,
    .cam_pos_valid, .encoder_present, .encoder_cable_ok, .module_type, .feed_value,
    .lower_limit, .upper_limit, .stroke_amount, .mode_state_flag, .switch_error_flag,
    .switch_error_info_words, .switch_busy, .motion_cmd_allow, .module_error_signal,
    .module_error_code, .system_start_block, .servo_off, .rapid_stop_all);
  mss_host_model u_host (.sys_clk, .mode_state_flag, .mode_switch_request, .host_ready_flag,
    .error_clear, .clutch_engaged, .motion_cmd_ok());
  // Free-running 100 MHz clock.
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // Next value of the sixteen-bit random generator.
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // Code left behind by each automatic fall-back cause.
  function automatic logic [15:0] fb_code(input int n);
    return (n == 0) ? MSS_ERR_FORCED_STOP : (n == 1) ? MSS_ERR_HOST_UNREADY : MSS_ERR_SERVO;
  endfunction
  // Compares one flag.
  task automatic cmpb(input string nm, input logic e, input logic g);
    n_checks++;
    if (g !== e)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Compares one word or vector.
  task automatic cmpw(input string nm, input logic [47:0] e, input logic [47:0] g);
    n_checks++;
    if (g !== e)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Waits whole cycles and lands just past the last edge.
  task automatic go(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // Records busy, command lockout and rapid stop seen over some cycles.
  task automatic watch(input int n);
    seen = '0;
    repeat (n)
    begin
      go(1);
      seen |= {switch_busy, !motion_cmd_allow, rapid_stop_all};
    end
  endtask
  // Puts every axis in a state that passes all checks, with a random feed.
  task automatic base();
    {axis_start_accept_flags, axis_is_virtual, servo_error_signal, stop_input} = '0;
    {clutch_ext_mode, enc_serial_abs, clutch_addr_mode, addr_dev_lsb, two_way_cam} = '0;
    {servo_ready_signal, clutch_same_dev, cam_pos_valid, encoder_present, encoder_cable_ok} = '1;
    {module_type, lower_limit, old_firmware} = '0;
    stroke_amount = {MSS_AXES{32'h00001000}};
    upper_limit = {MSS_AXES{20'h00001, seed[15:4]}};
    feed_value = {MSS_AXES{20'h00000, seed[11:0]}};
  endtask
  // Turns one axis into a cam module with the given stroke setup.
  task automatic cam(input int x, input logic [31:0] lo, st, fd, input logic t, v);
    module_type[x*2+:2] = MSS_TYPE_CAM;
    lower_limit[x*32+:32] = lo;
    stroke_amount[x*32+:32] = st;
    feed_value[x*32+:32] = fd;
    two_way_cam[x] = t;
    cam_pos_valid[x] = v;
  endtask
  // Prints the verdict and ends the run.
  task automatic close_out();
    if (errors == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Cuts a hang short.
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      errors++;
      close_out();
    end
  end
  // Main sequence of scenarios.
  initial
  begin
    seed = 16'hCCF7;
    mod_code = '{MSS_MOD_SERVO_RDY, MSS_MOD_STROKE, MSS_MOD_TWO_WAY, MSS_MOD_CLUTCH_DEV,
      MSS_MOD_ENC_IF, MSS_MOD_STOP_IN, MSS_MOD_CAM_POS, MSS_MOD_ADDR_ODD};
    {rst_n, forced_stop, test_mode, test_req_virtual, test_req_real} = '0;
    {servo_policy_continue, clk_en} = 2'h1;
    base();
    repeat (10) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    cmpw("info", 48'h0, switch_error_info_words);
    k = seed[5:3];
    axis_start_accept_flags[k] = 1'b1;
    u_host.req(1'b1);
    go(4);
    cmpb("mode", 1'b0, mode_state_flag);
    cmpb("eflag", 1'b1, switch_error_flag);
    cmpw("info", 48'(MSS_ERR_AXIS_BUSY), switch_error_info_words);
    // One output module fault per axis, rotated by a random offset.
    seed = lfsr(seed);
    base();
    u_host.req(1'b0);
    r = seed[2:0];
    for (j = 0; j < 8; j++)
    begin
      a = (j + r) % 8;
      case (j)
        0: servo_ready_signal[a] = 1'b0;
        1: cam(a, 32'h00000000, 32'h00000010, 32'h00000011, 1'b0, 1'b1);
        2: cam(a, 32'h7FFFFFF0, 32'h7FFFFFF8, 32'h7FFFFFF4, 1'b1, 1'b1);
        3: {clutch_ext_mode[a], clutch_same_dev[a]} = 2'h2;
        4: {clutch_ext_mode[a], enc_serial_abs[a]} = 2'h3;
        5: stop_input[a] = 1'b1;
        6: cam(a, 32'h00000000, 32'h00000010, 32'h00000004, 1'b1, 1'b0);
        default: {clutch_addr_mode[a], addr_dev_lsb[a]} = 2'h3;
      endcase
    end
    u_host.req(1'b1);
    watch(4);
    cmpw("lockout", 48'h6, 48'(seen));
    cmpb("mode", 1'b1, mode_state_flag);
    cmpb("eflag", 1'b0, switch_error_flag);
    for (j = 0; j < 8; j++)
    begin
      a = (j + r) % 8;
      cmpb("merr", 1'b1, module_error_signal[a]);
      cmpw("mcode", 48'(mod_code[j]), 48'(module_error_code[a*16+:16]));
      cmpb("block", 1'b1, system_start_block[a]);
    end
    // Back to real: busy virtual axis, busy real axis on old firmware, then busy real axis on new firmware.
    for (c = 0; c < 3; c++)
    begin
      seed = lfsr(seed);
      if (c > 0)
        u_host.req(1'b1);
      axis_start_accept_flags = 8'h01 << seed[2:0];
      axis_is_virtual = {MSS_AXES{c == 0}};
      old_firmware = (c == 1);
      u_host.req(1'b0);
      go(4);
      cmpb("mode", c != 2, mode_state_flag);
      cmpb("eflag", c != 2, switch_error_flag);
      cmpw("info", (c == 2) ? 48'h0 : 48'(MSS_ERR_AXIS_BUSY), switch_error_info_words);
    end
    base();
    u_host.clr();
    go(1);
    cmpw("merr", 48'h0, 48'(module_error_signal | system_start_block));
    // Forced stop, host unready and a servo error each fall back to real mode.
    for (c = 0; c < 3; c++)
    begin
      seed = lfsr(seed);
      k = seed[2:0];
      {encoder_present[k], encoder_cable_ok[k]} = {seed[3], !seed[3]};
      u_host.req(1'b0);
      u_host.req(1'b1);
      go(4);
      cmpb("merr", 1'b1, module_error_signal[k]);
      cmpw("mcode", 48'(MSS_MOD_ENCODER), 48'(module_error_code[k*16+:16]));
      cmpb("mode", 1'b1, mode_state_flag);
      if (c == 0)
        forced_stop = 1'b1;
      else if (c == 1)
        u_host.rdy(1'b0);
      else
        servo_error_signal[k] = 1'b1;
      watch(4);
      cmpb("rstop", 1'b1, seen[0]);
      cmpb("mode", 1'b0, mode_state_flag);
      cmpb("eflag", 1'b0, switch_error_flag);
      cmpw("info", 48'(fb_code(c)), switch_error_info_words);
      if (c == 2)
        cmpw("soff", 48'(8'h01 << k), 48'(servo_off));
      base();
      forced_stop = 1'b0;
      u_host.rdy(1'b1);
      if (c == 2)
      begin
        u_host.req(1'b0);
        u_host.req(1'b1);
        go(4);
        cmpb("mode", 1'b0, mode_state_flag);
        cmpw("info", 48'(MSS_ERR_PREV_FAULT), switch_error_info_words);
      end
      u_host.clr();
    end
    // Continue policy keeps virtual mode and turns off only the failing servo.
    servo_policy_continue = 1'b1;
    u_host.req(1'b0);
    u_host.req(1'b1);
    go(4);
    u_host.eng(seed[15:8]);
    servo_error_signal[k] = 1'b1;
    go(4);
    cmpb("mode", 1'b1, mode_state_flag);
    cmpw("soff", 48'(8'h01 << k), 48'(servo_off));
    servo_error_signal = '0;
    u_host.clr();
    go(1);
    cmpw("soff", 48'h0, 48'(servo_off));
    cmpb("mode", 1'b1, mode_state_flag);
    // In test mode the host flag is ignored and tool pulses switch the mode.
    test_mode = 1'b1;
    u_host.req(1'b0);
    go(4);
    cmpb("mode", 1'b1, mode_state_flag);
    for (c = 0; c < 2; c++)
    begin
      {test_req_real, test_req_virtual} = (c == 0) ? 2'h2 : 2'h1;
      go(1);
      {test_req_real, test_req_virtual} = 2'h0;
      go(4);
      cmpb("mode", c == 1, mode_state_flag);
    end
    // A low clock enable freezes the mode through a tool request.
    clk_en = 1'b0;
    test_req_real = 1'b1;
    go(1);
    test_req_real = 1'b0;
    go(4);
    cmpb("mode", 1'b1, mode_state_flag);
    clk_en = 1'b1;
    close_out();
  end
endmodule // mode_switch_supervisor_tb_top
`default_nettype wire

// file: sim/mss_host_model.sv
// Host program model that owns the switch request, ready, clear and clutch lines.
`timescale 1ns/1ns
`default_nettype none
module mss_host_model
  import mss_pkg::*;
#(
  parameter int unsigned AXES = MSS_AXES
)(
  // Clock.
  input wire logic sys_clk,
  // Device status.
  input wire logic mode_state_flag,
  // Host flags.
  output logic mode_switch_request,
  output logic host_ready_flag,
  output logic error_clear,
  output logic [AXES-1:0] clutch_engaged,
  output logic motion_cmd_ok
);
  // The host starts ready, with no request and the clutches open.
  initial
  begin
    mode_switch_request = 1'b0;
    host_ready_flag = 1'b1;
    error_clear = 1'b0;
    clutch_engaged = '0;
  end
  // Motion commands go out only while request and status agree.
  assign motion_cmd_ok = (mode_switch_request == mode_state_flag);
  // Sets the request level just after the next edge.
  task automatic req(input logic v);
    @(posedge sys_clk);
    #1 mode_switch_request = v;
  endtask
  // Changes the ready level at once; callers are already just past an edge.
  task automatic rdy(input logic v);
    host_ready_flag = v;
  endtask
  // Opens the clutch first, so a driven axis cannot lurch, then pulses the clear.
  task automatic clr();
    @(posedge sys_clk);
    #1 clutch_engaged = '0;
    @(posedge sys_clk);
    #1 error_clear = 1'b1;
    @(posedge sys_clk);
    #1 error_clear = 1'b0;
  endtask
  // Engages the given clutches just after the next edge.
  task automatic eng(input logic [AXES-1:0] m);
    @(posedge sys_clk);
    #1 clutch_engaged = m;
  endtask
endmodule // mss_host_model
`default_nettype wire
